// File: ldp_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module ldp_panel_model (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // palette lookup
   input  wire logic [7:0]  lut_index,
   output wire logic [17:0] lut_rgb,
   // panel timing
   output wire logic        line_pulse,
   output wire logic        frame_pulse,
   output wire logic        vert_nondisplay
);
   logic [3:0] dot_q;
   logic [2:0] line_q;
   // short lines keep the run small: 16 cycles a line, 8 lines a frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dot_q  <= 4'h0;
         line_q <= 3'h0;
      end else begin
         dot_q <= dot_q + 4'h1;
         if (dot_q == 4'hF) begin
            line_q <= line_q + 3'h1;
         end
      end
   end
   assign line_pulse      = (dot_q == 4'hF);
   // frame start kept apart from the line pulse on purpose
   assign frame_pulse     = (line_q == 3'h0) && (dot_q == 4'h8);
   assign vert_nondisplay = line_q[2] && line_q[1];
   assign lut_rgb         = {lut_index[5:0], ~lut_index[5:0], lut_index[7:2]};
endmodule : ldp_panel_model
`default_nettype wire

// File: ldp_pkg.sv
package ldp_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] LDP_PANEL_OFS    = 8'h0C;
   localparam logic [7:0] LDP_DISP_OFS     = 8'h10;
   localparam logic [7:0] LDP_PSAVE_OFS    = 8'h14;
   localparam logic [7:0] LDP_OVL_ADDR_OFS = 8'h50;
   localparam logic [7:0] LDP_OVL_LOFS_OFS = 8'h54;
   localparam logic [7:0] LDP_OVL_X_OFS    = 8'h58;
   localparam logic [7:0] LDP_OVL_Y_OFS    = 8'h5C;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int LDP_PTYPE_LSB  = 0;
   localparam int LDP_MODR_LSB   = 16;
   localparam int LDP_BPP_LSB    = 0;
   localparam int LDP_ROT_LSB    = 16;
   localparam int LDP_OVL_BIT    = 19;
   localparam int LDP_INV_BIT    = 20;
   localparam int LDP_DITH_BIT   = 22;
   localparam int LDP_BLANK_BIT  = 23;
   localparam int LDP_DBLH_BIT   = 24;
   localparam int LDP_DBLV_BIT   = 25;
   localparam int LDP_GPO_BIT    = 0;
   localparam int LDP_PSEN_BIT   = 4;
   localparam int LDP_MPD_BIT    = 6;
   localparam int LDP_VND_BIT    = 7;
   // ----------------------------------------------------------------
   // writable masks and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] LDP_PANEL_MASK = 32'h003F_0003;
   localparam logic [31:0] LDP_DISP_MASK  = 32'h03DB_001F;
   localparam logic [31:0] LDP_PSAVE_MASK = 32'h0000_0011;
   localparam logic [31:0] LDP_PANEL_RST  = 32'h0000_0000;
   localparam logic [31:0] LDP_DISP_RST   = 32'h0000_0000;
   localparam logic [31:0] LDP_PSAVE_RST  = 32'h0000_0010;
   localparam logic [31:0] LDP_OVL_RST    = 32'h0000_0000;
   // ----------------------------------------------------------------
   // codes
   // ----------------------------------------------------------------
   localparam logic [1:0] LDP_PT_STN    = 2'h0;
   localparam logic [1:0] LDP_PT_TFT    = 2'h1;
   localparam logic [1:0] LDP_PT_DIRECT = 2'h2;
   localparam logic [4:0] LDP_BPP_1     = 5'h01;
   localparam logic [4:0] LDP_BPP_2     = 5'h02;
   localparam logic [4:0] LDP_BPP_4     = 5'h04;
   localparam logic [4:0] LDP_BPP_8     = 5'h08;
   localparam logic [4:0] LDP_BPP_16    = 5'h10;
   localparam logic [1:0] LDP_HTRANS_NS = 2'h2;

   typedef enum logic [1:0] {
      LDP_ROT_0,
      LDP_ROT_90,
      LDP_ROT_180,
      LDP_ROT_270
   } ldp_rot_type;

   // pixel entering from the fetch engine
   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } ldp_pix_in_type;

   // pixel leaving towards the panel formatter
   typedef struct packed {
      logic        valid;
      logic [17:0] rgb;
   } ldp_pix_out_type;

   // settings handed to the fetch engine
   typedef struct packed {
      logic        dbl_v;
      logic        dbl_h;
      logic        ovl_en;
      ldp_rot_type rot;
      logic [4:0]  bpp;
      logic [31:0] ovl_addr;
      logic [31:0] ovl_lofs;
      logic [31:0] ovl_x;
      logic [31:0] ovl_y;
   } ldp_fetch_cfg_type;
endpackage : ldp_pkg

// File: ldp_top.sv
`timescale 1ns/1ps
`default_nettype none
module ldp_top
   import ldp_pkg::*;
#(
   parameter int MOD_CNT_W = 6
) (
   // clock and reset
   input  wire  logic                      hclk,
   input  wire  logic                      hresetn,
   // ahb-lite slave
   input  wire  logic                      hsel,
   input  wire  logic [31:0]               haddr,
   input  wire  logic [1:0]                htrans,
   input  wire  logic                      hwrite,
   input  wire  logic [2:0]                hsize,
   input  wire  logic                      hready,
   input  wire  logic [31:0]               hwdata,
   output var   logic [31:0]               hrdata,
   output var   logic                      hreadyout,
   output var   logic                      hresp,
   // display timing, same clock
   input  wire  logic                      line_pulse,
   input  wire  logic                      frame_pulse,
   input  wire  logic                      vert_nondisplay,
   // pixel stream and palette
   input  wire  ldp_pkg::ldp_pix_in_type   pix_in,
   output var   logic                      pix_ready,
   output var   logic [7:0]                lut_index,
   input  wire  logic [17:0]               lut_rgb,
   output var   ldp_pkg::ldp_pix_out_type  pix_out,
   // memory controller
   input  wire  logic                      mem_wr_req,
   input  wire  logic                      mem_idle,
   output var   logic                      mem_ctrl_en,
   // panel side
   output var   logic [1:0]                panel_type,
   output var   logic                      panel_modulation_pin,
   output var   logic                      line_repeat,
   output var   ldp_pkg::ldp_fetch_cfg_type fetch_cfg
);
   import ldp_pkg::*;

   if (MOD_CNT_W < 6) begin : g_chk
      $error("MOD_CNT_W must hold the six-bit modulation rate");
   end

   // ----------------------------------------------------------------
   // bus address phase capture
   // ----------------------------------------------------------------
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic        take;

   assign take = hsel && hready && (htrans == LDP_HTRANS_NS);
   // registers answer with no wait state and never signal an error
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= take && hwrite;
         wr_addr_q <= haddr[7:0];
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [31:0] panel_q;
   logic [31:0] disp_q;
   logic [31:0] psave_q;
   logic [31:0] ovl_addr_q;
   logic [31:0] ovl_lofs_q;
   logic [31:0] ovl_x_q;
   logic [31:0] ovl_y_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         panel_q    <= LDP_PANEL_RST;
         disp_q     <= LDP_DISP_RST;
         psave_q    <= LDP_PSAVE_RST;
         ovl_addr_q <= LDP_OVL_RST;
         ovl_lofs_q <= LDP_OVL_RST;
         ovl_x_q    <= LDP_OVL_RST;
         ovl_y_q    <= LDP_OVL_RST;
      end else if (wr_pend_q) begin
         case (wr_addr_q)
            LDP_PANEL_OFS:    panel_q    <= hwdata & LDP_PANEL_MASK;
            LDP_DISP_OFS:     disp_q     <= hwdata & LDP_DISP_MASK;
            LDP_PSAVE_OFS:    psave_q    <= hwdata & LDP_PSAVE_MASK;
            LDP_OVL_ADDR_OFS: ovl_addr_q <= hwdata;
            LDP_OVL_LOFS_OFS: ovl_lofs_q <= hwdata;
            LDP_OVL_X_OFS:    ovl_x_q    <= hwdata;
            LDP_OVL_Y_OFS:    ovl_y_q    <= hwdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // decoded fields
   // ----------------------------------------------------------------
   logic [1:0]  ptype;
   logic [5:0]  mod_rate;
   logic [4:0]  bpp;
   logic        blank;
   logic        dith_off;
   logic        inv;
   logic        dbl_h;
   logic        dbl_v;
   logic        ps_en;

   assign ptype    = panel_q[LDP_PTYPE_LSB +: 2];
   assign mod_rate = panel_q[LDP_MODR_LSB +: 6];
   assign bpp      = disp_q[LDP_BPP_LSB +: 5];
   assign blank    = disp_q[LDP_BLANK_BIT];
   assign dith_off = disp_q[LDP_DITH_BIT];
   assign inv      = disp_q[LDP_INV_BIT];
   assign dbl_h    = disp_q[LDP_DBLH_BIT];
   assign dbl_v    = disp_q[LDP_DBLV_BIT];
   assign ps_en    = psave_q[LDP_PSEN_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         panel_type <= LDP_PT_STN;
      end else begin
         panel_type <= ptype;
      end
   end

   // overlay shares depth and rotation with the main window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fetch_cfg <= '0;
      end else begin
         fetch_cfg.dbl_v    <= dbl_v;
         fetch_cfg.dbl_h    <= dbl_h;
         fetch_cfg.ovl_en   <= disp_q[LDP_OVL_BIT];
         fetch_cfg.rot      <= ldp_rot_type'(disp_q[LDP_ROT_LSB +: 2]);
         fetch_cfg.bpp      <= bpp;
         fetch_cfg.ovl_addr <= ovl_addr_q;
         fetch_cfg.ovl_lofs <= ovl_lofs_q;
         fetch_cfg.ovl_x    <= ovl_x_q;
         fetch_cfg.ovl_y    <= ovl_y_q;
      end
   end

   // ----------------------------------------------------------------
   // power save and memory controller
   // ----------------------------------------------------------------
   logic mem_down_q;

   // a buffer write wakes the controller for its own duration only
   assign mem_ctrl_en = !ps_en || mem_wr_req;
   // status lags its inputs by one edge; software polls it, so the lag is harmless

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_down_q <= 1'b0;
      end else begin
         mem_down_q <= ps_en && !mem_wr_req && mem_idle;
      end
   end

   // ----------------------------------------------------------------
   // read data, registered in the address phase
   // ----------------------------------------------------------------
   logic [31:0] psave_rd;
   logic        fwd;

   // a read right behind a write to the same word sees the word being
   // written, so back-to-back transfers need no idle cycle
   assign fwd = wr_pend_q && (wr_addr_q == haddr[7:0]);

   always_comb begin
      psave_rd              = fwd ? (hwdata & LDP_PSAVE_MASK) : psave_q;
      psave_rd[LDP_VND_BIT] = vert_nondisplay;
      psave_rd[LDP_MPD_BIT] = mem_down_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         case (haddr[7:0])
            LDP_PANEL_OFS:    hrdata <= fwd ? (hwdata & LDP_PANEL_MASK) : panel_q;
            LDP_DISP_OFS:     hrdata <= fwd ? (hwdata & LDP_DISP_MASK) : disp_q;
            LDP_PSAVE_OFS:    hrdata <= psave_rd;
            LDP_OVL_ADDR_OFS: hrdata <= fwd ? hwdata : ovl_addr_q;
            LDP_OVL_LOFS_OFS: hrdata <= fwd ? hwdata : ovl_lofs_q;
            LDP_OVL_X_OFS:    hrdata <= fwd ? hwdata : ovl_x_q;
            LDP_OVL_Y_OFS:    hrdata <= fwd ? hwdata : ovl_y_q;
            default:          hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // vertical doubling: every other line is fetched again
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_repeat <= 1'b0;
      end else if (!dbl_v || frame_pulse) begin
         line_repeat <= 1'b0;
      end else if (line_pulse) begin
         line_repeat <= !line_repeat;
      end
   end

   // ----------------------------------------------------------------
   // pixel pipeline
   // ----------------------------------------------------------------
   logic        second_q;
   logic        hold_v_q;
   logic [15:0] hold_d_q;
   logic        use_v;
   logic [15:0] use_d;
   logic [17:0] rgb;
   logic [17:0] rgb_c;

   // horizontal doubling presents each pixel twice; the fetch side
   // is stalled for the repeat, so its rate halves
   // the repeat slot still blocks if doubling is switched off inside it
   assign pix_ready = !blank && !second_q;
   assign use_v     = second_q ? hold_v_q : pix_in.valid;
   assign use_d     = second_q ? hold_d_q : pix_in.data;
   assign lut_index = use_d[7:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         second_q <= 1'b0;
         hold_v_q <= 1'b0;
         hold_d_q <= 16'h0000;
      end else if (blank || !dbl_h) begin
         second_q <= 1'b0;
         hold_v_q <= 1'b0;
      end else if (second_q) begin
         second_q <= 1'b0;
      end else if (pix_in.valid) begin
         second_q <= 1'b1;
         hold_v_q <= 1'b1;
         hold_d_q <= pix_in.data;
      end
   end

   always_comb begin
      // 16 bpp is 5-6-5 and skips the palette; lower depths look it up
      if (bpp == LDP_BPP_16) begin
         rgb = {use_d[15:11], use_d[15], use_d[10:5], use_d[4:0], use_d[4]};
      end else begin
         rgb = lut_rgb;
      end
      if (inv) begin
         rgb = ~rgb;
      end
      rgb_c = rgb;
      // without dithering a passive panel keeps 4 bits per colour
      if (ptype == LDP_PT_STN && dith_off) begin
         rgb_c = {rgb[17:14], 2'h0, rgb[11:8], 2'h0, rgb[5:2], 2'h0};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pix_out <= '0;
      end else if (blank) begin
         pix_out <= '0;
      end else begin
         pix_out.valid <= use_v;
         pix_out.rgb   <= use_v ? rgb_c : 18'h00000;
      end
   end

   // ----------------------------------------------------------------
   // modulation pin
   // ----------------------------------------------------------------
   logic [MOD_CNT_W-1:0] mod_cnt_q;
   logic                 mod_q;
   logic                 mod_step;

   // a rate change does not clear the counter, so the first period after it may be short
   assign mod_step = (mod_rate == 6'h00) ? frame_pulse : line_pulse;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mod_cnt_q <= '0;
         mod_q     <= 1'b0;
      end else if (mod_step) begin
         if (mod_rate == 6'h00) begin
            mod_q <= !mod_q;
         end else if (mod_cnt_q + 1'b1 >= MOD_CNT_W'(mod_rate)) begin
            mod_cnt_q <= '0;
            mod_q     <= !mod_q;
         end else begin
            mod_cnt_q <= mod_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         panel_modulation_pin <= 1'b0;
      end else begin
         case (ptype)
            LDP_PT_STN:    panel_modulation_pin <= mod_q;
            LDP_PT_TFT:    panel_modulation_pin <= use_v && !blank;
            LDP_PT_DIRECT: panel_modulation_pin <= psave_q[LDP_GPO_BIT];
            default:       panel_modulation_pin <= 1'b0;
         endcase
      end
   end
endmodule : ldp_top
`default_nettype wire

// File: ldp_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ldp_top_sva
   import ldp_pkg::*;
#(
   parameter int MOD_CNT_W = 6
) (
   // clock and reset
   input wire logic                       hclk,
   input wire logic                       hresetn,
   // register bus
   input wire logic                       hsel,
   input wire logic [31:0]                haddr,
   input wire logic [1:0]                 htrans,
   input wire logic                       hwrite,
   input wire logic                       hready,
   input wire logic [31:0]                hwdata,
   // timing and pixels
   input wire logic                       line_pulse,
   input wire logic                       frame_pulse,
   input wire ldp_pkg::ldp_pix_in_type    pix_in,
   input wire logic                       pix_ready,
   input wire logic [7:0]                 lut_index,
   input wire ldp_pkg::ldp_pix_out_type   pix_out,
   // memory and panel
   input wire logic                       mem_wr_req,
   input wire logic                       mem_ctrl_en,
   input wire logic [1:0]                 panel_type,
   input wire logic                       line_repeat,
   input wire ldp_pkg::ldp_fetch_cfg_type fetch_cfg
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic wr_take;
   assign wr_take = hsel && hready && (htrans == LDP_HTRANS_NS) && hwrite;
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   // copies are checked two edges after the data phase, so either lag passes
   property p_cfg;
      wr_take && haddr[7:0] == LDP_DISP_OFS ##1 1'b1 |=> ##1
         (fetch_cfg.bpp == $past(hwdata[4:0], 2) && fetch_cfg.rot == $past(hwdata[17:16], 2)
         && fetch_cfg.ovl_en == $past(hwdata[19], 2) && fetch_cfg.dbl_h == $past(hwdata[24], 2)
         && fetch_cfg.dbl_v == $past(hwdata[25], 2));
   endproperty
   a_cfg: assert property (p_cfg) else $error("fetch settings differ from write");
   property p_ptype;
      wr_take && haddr[7:0] == LDP_PANEL_OFS ##1 1'b1 |=> ##1 panel_type == $past(hwdata[1:0], 2);
   endproperty
   a_ptype: assert property (p_ptype) else $error("panel type differs from write");
   property p_dblh;
      fetch_cfg.dbl_h && pix_in.valid && pix_ready |=>
         !pix_ready ##1 (pix_out.valid && $stable(pix_out.rgb));
   endproperty
   a_dblh: assert property (p_dblh) else $error("pixel not repeated");
   property p_pass;
      !fetch_cfg.dbl_h && pix_in.valid && pix_ready |=> pix_out.valid;
   endproperty
   a_pass: assert property (p_pass) else $error("accepted pixel not output");
   property p_lut;
      pix_in.valid && pix_ready |-> lut_index == pix_in.data[7:0];
   endproperty
   a_lut: assert property (p_lut) else $error("palette index wrong");
   property p_frame;
      frame_pulse |=> !line_repeat;
   endproperty
   a_frame: assert property (p_frame) else $error("repeat not cleared at frame");
   // enable seen one cycle late matches the register at the pulse
   property p_line;
      line_pulse && !frame_pulse ##1 fetch_cfg.dbl_v |-> line_repeat != $past(line_repeat);
   endproperty
   a_line: assert property (p_line) else $error("line repeat did not toggle");
   property p_wake;
      mem_wr_req |-> mem_ctrl_en;
   endproperty
   a_wake: assert property (p_wake) else $error("memory not woken for write");
endmodule : ldp_top_sva

bind ldp_top ldp_top_sva #(.MOD_CNT_W(MOD_CNT_W)) u_ldp_sva (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hwdata(hwdata), .line_pulse(line_pulse), .frame_pulse(frame_pulse), .pix_in(pix_in),
   .pix_ready(pix_ready), .lut_index(lut_index), .pix_out(pix_out), .mem_wr_req(mem_wr_req),
   .mem_ctrl_en(mem_ctrl_en), .panel_type(panel_type), .line_repeat(line_repeat),
   .fetch_cfg(fetch_cfg));
`default_nettype wire

// File: tb_ldp_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ldp_top;
   import ldp_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0]       haddr = 32'h0, hwdata = 32'h0, q;
   logic [1:0]        htrans = 2'h0;
   logic              mem_wr_req = 1'b0, mem_idle = 1'b0, p1;
   ldp_pix_in_type    pix_in = '0;
   wire logic [31:0]  hrdata;
   wire logic         hreadyout, hresp, pix_ready, mem_ctrl_en, panel_modulation_pin;
   wire logic         line_repeat, line_pulse, frame_pulse, vert_nondisplay;
   wire logic [7:0]   lut_index;
   wire logic [17:0]  lut_rgb;
   wire logic [1:0]   panel_type;
   wire ldp_pix_out_type   pix_out;
   wire ldp_fetch_cfg_type fetch_cfg;
   int                num_errors = 0, n_checks = 0;
   always #2.5 hclk = ~hclk;
   ldp_top #(.MOD_CNT_W(6)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .line_pulse(line_pulse),
      .frame_pulse(frame_pulse), .vert_nondisplay(vert_nondisplay), .pix_in(pix_in),
      .pix_ready(pix_ready), .lut_index(lut_index), .lut_rgb(lut_rgb), .pix_out(pix_out),
      .mem_wr_req(mem_wr_req), .mem_idle(mem_idle), .mem_ctrl_en(mem_ctrl_en),
      .panel_type(panel_type), .panel_modulation_pin(panel_modulation_pin),
      .line_repeat(line_repeat), .fetch_cfg(fetch_cfg));
   ldp_panel_model u_panel (.hclk(hclk), .hresetn(hresetn), .lut_index(lut_index),
      .lut_rgb(lut_rgb), .line_pulse(line_pulse), .frame_pulse(frame_pulse),
      .vert_nondisplay(vert_nondisplay));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task automatic bail(input logic t);
      if (t) begin
         num_errors++;
         finish_test();
      end
   endtask : bail
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // sel high waits on the line pulse, low on the vertical blank level
   task automatic wait_lvl(input logic sel, input logic k);
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while ((sel ? line_pulse : vert_nondisplay) !== k && n < 500);
      bail(n >= 500);
   endtask : wait_lvl
   task automatic wait_bus();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      bail(n >= 50);
   endtask : wait_bus
   // one single transfer; the next call starts an edge later, leaving an idle cycle
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= LDP_HTRANS_NS;
      hwrite <= wr;
      wait_bus();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_bus();
      q = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask : ahb
   function automatic logic [17:0] pal(input logic [7:0] i);
      return {i[5:0], ~i[5:0], i[7:2]};
   endfunction : pal
   task automatic send(input logic [15:0] d, input logic [17:0] e);
      int n;
      @(posedge hclk);
      pix_in <= {1'b1, d};
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (pix_ready !== 1'b1 && n < 50);
      bail(n >= 50);
      @(posedge hclk);
      pix_in <= '0;
      @(negedge hclk);
      check({13'h0, pix_out}, {13'h0, 1'b1, e});
   endtask : send
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      ahb(1'b0, LDP_DISP_OFS, 32'h0);
      check(q, LDP_DISP_RST);
      ahb(1'b0, LDP_PSAVE_OFS, 32'h0);
      check(q & 32'hFFFF_FF3F, LDP_PSAVE_RST);
      check({31'h0, mem_ctrl_en}, 32'h0);
      ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
      ahb(1'b0, 8'h40, 32'h0);
      check(q, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_regs();
      logic [4:0] b;
      ahb(1'b1, LDP_DISP_OFS, 32'hFFFC_FFE8);
      ahb(1'b0, LDP_DISP_OFS, 32'h0);
      check(q, 32'h03D8_0008);
      for (int i = 0; i < 5; i++) begin
         b = 5'h01 << i;
         ahb(1'b1, LDP_DISP_OFS, {12'h0, i[0], 1'b0, i[1:0], 11'h0, b});
         repeat (2) @(posedge hclk);
         check({27'h0, fetch_cfg.bpp}, {27'h0, b});
         check({30'h0, fetch_cfg.rot}, {30'h0, i[1:0]});
         check({31'h0, fetch_cfg.ovl_en}, {31'h0, i[0]});
      end
      for (int j = 0; j < 4; j++) begin
         ahb(1'b1, LDP_OVL_ADDR_OFS + 8'(4 * j), 32'hA500_0000 + j);
         ahb(1'b0, LDP_OVL_ADDR_OFS + 8'(4 * j), 32'h0);
         check(q, 32'hA500_0000 + j);
      end
      check(fetch_cfg.ovl_y, 32'hA500_0003);
      $display("test regs done");
   endtask : t_regs
   task automatic t_psave();
      mem_idle <= 1'b1;
      ahb(1'b0, LDP_PSAVE_OFS, 32'h0);
      check(q & 32'h50, 32'h50);
      mem_wr_req <= 1'b1;
      @(posedge hclk);
      check({31'h0, mem_ctrl_en}, 32'h1);
      ahb(1'b0, LDP_PSAVE_OFS, 32'h0);
      check(q & 32'h50, 32'h10);
      mem_wr_req <= 1'b0;
      ahb(1'b1, LDP_PSAVE_OFS, 32'h0);
      ahb(1'b0, LDP_PSAVE_OFS, 32'h0);
      check(q & 32'hFFFF_FF7F, 32'h0);
      check({31'h0, mem_ctrl_en}, 32'h1);
      $display("test psave done");
   endtask : t_psave
   task automatic t_vnd();
      for (int k = 0; k < 2; k++) begin
         wait_lvl(1'b0, ~k[0]);
         wait_lvl(1'b0, k[0]);
         ahb(1'b0, LDP_PSAVE_OFS, 32'h0);
         check({31'h0, q[7]}, {31'h0, k[0]});
      end
      $display("test vnd done");
   endtask : t_vnd
   task automatic t_pix();
      ahb(1'b1, LDP_PANEL_OFS, {30'h0, LDP_PT_TFT});
      ahb(1'b1, LDP_DISP_OFS, {27'h0, LDP_BPP_8});
      send(16'h1234, pal(8'h34));
      ahb(1'b1, LDP_DISP_OFS, 32'h0010_0008);
      send(16'h0056, ~pal(8'h56));
      ahb(1'b1, LDP_PANEL_OFS, {30'h0, LDP_PT_STN});
      ahb(1'b1, LDP_DISP_OFS, 32'h0040_0008);
      send(16'h0077, pal(8'h77) & 18'h3CF3C);
      ahb(1'b1, LDP_DISP_OFS, 32'h0000_0008);
      send(16'h0077, pal(8'h77));
      ahb(1'b1, LDP_DISP_OFS, 32'h0300_0008);
      send(16'h0011, pal(8'h11));
      repeat (60) @(posedge hclk);
      ahb(1'b1, LDP_DISP_OFS, {27'h0, LDP_BPP_16});
      send(16'h07E0, 18'h00FC0);
      ahb(1'b1, LDP_DISP_OFS, 32'h0080_0008);
      @(posedge hclk);
      pix_in <= {1'b1, 16'h00FF};
      @(posedge hclk);
      @(negedge hclk);
      check({12'h0, pix_ready, pix_out}, 32'h0);
      @(posedge hclk);
      pix_in <= '0;
      $display("test pix done");
   endtask : t_pix
   task automatic t_gpo();
      ahb(1'b1, LDP_PANEL_OFS, {30'h0, LDP_PT_DIRECT});
      for (int b = 0; b < 2; b++) begin
         ahb(1'b1, LDP_PSAVE_OFS, {31'h0, b[0]});
         repeat (3) @(posedge hclk);
         check({31'h0, panel_modulation_pin}, {31'h0, b[0]});
      end
      // two lines a period, so a per-line toggle would show no change
      ahb(1'b1, LDP_PANEL_OFS, 32'h0002_0000);
      // let a counter left anywhere wrap before the toggle is measured
      repeat (66) wait_lvl(1'b1, 1'b1);
      repeat (3) @(posedge hclk);
      p1 = panel_modulation_pin;
      repeat (2) wait_lvl(1'b1, 1'b1);
      repeat (3) @(posedge hclk);
      check({31'h0, p1 ^ panel_modulation_pin}, 32'h1);
      // zero rate: one toggle between two starts of vertical blank
      ahb(1'b1, LDP_PANEL_OFS, 32'h0);
      wait_lvl(1'b0, 1'b0);
      wait_lvl(1'b0, 1'b1);
      p1 = panel_modulation_pin;
      wait_lvl(1'b0, 1'b0);
      wait_lvl(1'b0, 1'b1);
      check({31'h0, p1 ^ panel_modulation_pin}, 32'h1);
      $display("test gpo done");
   endtask : t_gpo
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_regs();
      t_psave();
      t_vnd();
      t_pix();
      t_gpo();
      finish_test();
   end
endmodule : tb_ldp_top
`default_nettype wire
